// >>> hw/fsvp_decode.sv
// combinational decode of the two guard words into protection levels
// assumes words are stable whenever valid is high
`timescale 1ns/100ps
`include "fsvp_defines.svh"
module fsvp_decode
  import fsvp_pkg::*;
(
  fsvp_guard_if.dst       g,
  input  wire logic [2:0] modeSelectPins,
  input  wire fsvp_sect_t sectorPresent,
  output logic            readBlock,
  output logic            writeProtAll,
  output fsvp_sect_t      sectorLocked
);
  logic ctlOk;
  logic wpOn;
  logic intVec;
  // unlisted combinations leave protection off, so a blank part stays usable
  always_comb
  begin
    intVec = (modeSelectPins == `FSVP_MODE_INTERNAL_VECTOR_BOOT_MODE);
    ctlOk  = g.valid && (g.guardOne[31:19] == 13'h0000);
    readBlock = ctlOk && g.guardOne[`FSVP_BIT_READ_PROT] && !intVec;
    wpOn = ctlOk && g.guardOne[`FSVP_BIT_WRITE_PROT]
           && (!g.guardOne[`FSVP_BIT_WRITE_LEVEL] || !intVec);
    writeProtAll = wpOn;
  end
  // per-sector locks: bit value 0 protects; absent sectors never lock
  genvar i;
  generate
    for (i = 0; i < `FSVP_SECTORS; i++)
    begin : g_sect
      if (i < `FSVP_SMALL_SECTORS)
      begin : g_small
        assign sectorLocked[i] = wpOn && !g.guardOne[i] && sectorPresent[i];
      end
      else
      begin : g_big
        assign sectorLocked[i] = wpOn && !g.guardTwo[i - `FSVP_SMALL_SECTORS]
                                 && sectorPresent[i];
      end
    end
  endgenerate
endmodule

// >>> hw/fsvp_defines.svh
// flash security vector protection: addresses, field positions, timing counts
// assumes a 20 MHz core clock; included by the modules
`ifndef FSVP_DEFINES_SVH
`define FSVP_DEFINES_SVH
`define FSVP_ADDR_GUARD_ONE   24'h14_8000
`define FSVP_ADDR_BOOT_ONE    24'h14_8004
`define FSVP_ADDR_GUARD_TWO   24'h14_8008
`define FSVP_ADDR_BOOT_TWO    24'h14_800C
`define FSVP_BIT_READ_PROT    16
`define FSVP_BIT_WRITE_PROT   17
`define FSVP_BIT_WRITE_LEVEL  18
`define FSVP_MODE_INTERNAL_VECTOR_BOOT_MODE     3'h0
`define FSVP_MODE_PARALLEL    3'h7
`define FSVP_SMALL_SECTORS    8
`define FSVP_BIG_SECTORS      16
`define FSVP_SECTORS          24
`define FSVP_SECTOR_FOUR      4
// programmer-side waits in 50 ns cycles; the device never counts these itself
`define FSVP_POWER_ON_WAIT    55200
`define FSVP_INIT_WAIT        20000
`endif

// >>> hw/fsvp_guard_if.sv
// raw guard words and valid passed from the fetcher to the decoder
// assumes one clock domain
`timescale 1ns/100ps
interface fsvp_guard_if;
  logic [31:0] guardOne;
  logic [31:0] guardTwo;
  logic        valid;
  modport src (output guardOne, output guardTwo, output valid);
  modport dst (input guardOne, input guardTwo, input valid);
endinterface

// >>> hw/fsvp_pkg.sv
// flash security vector protection: shared types
// assumes the defines header is on the include path
package fsvp_pkg;
  typedef enum logic [4:0] {
    FSVP_IDLE   = 5'b00001,
    FSVP_REQ1   = 5'b00010,
    FSVP_REQ2   = 5'b00100,
    FSVP_DONE   = 5'b01000,
    FSVP_SPARE  = 5'b10000
  } fsvp_state_e;
  typedef logic [23:0] fsvp_sect_t;
endpackage

// >>> hw/fsvp_top.sv
// flash security vector protection: fetches guard words after reset and gates flash access
// assumes a single-word flash read port on sys_clk; mode pins and init reset are async pins
//
// Notes on behaviour
// - fetch vectors first, withhold access until done
// - guard words at 0x14_8000 and 0x14_8008
// - read protection except internal vector mode
// - write protection everywhere when level bit clear
// - level bit set exempts internal vector mode
// - word one low bits lock small sectors
// - bit n locks small sector n when zero
// - word two locks big sectors when enabled
// - word two bit n maps sector n+8
`timescale 1ns/100ps
`include "fsvp_defines.svh"
module fsvp_top
  import fsvp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  input  wire logic        external_init_reset_n,
  input  wire logic [2:0]  mode_select_pins,
  input  wire fsvp_sect_t  sectorPresent,
  output logic             fetchReq,
  output logic [23:0]      fetchAddr,
  input  wire logic        fetchAck,
  input  wire logic [31:0] fetchData,
  input  wire logic        accRead,
  input  wire logic        accWrite,
  input  wire logic [4:0]  accSector,
  output logic             accGrant,
  output logic             accDenied,
  output logic             vectorsReady,
  output logic             readBlocked,
  output logic             writeProtected,
  output fsvp_sect_t       sectorLocked,
  output logic             parallelMode,
  output logic [31:0]      flash_guard_word_one,
  output logic [31:0]      flash_guard_word_two
);
  logic        rstMeta_r;
  logic        rstSync_r;
  logic [2:0]  initSync_r;
  logic [5:0]  modeMeta_r;
  logic [5:0]  modeSync_r;
  fsvp_state_e state_r;
  fsvp_state_e state_nxt;
  logic [31:0] wOne_r;
  logic [31:0] wOne_nxt;
  logic [31:0] wTwo_r;
  logic [31:0] wTwo_nxt;
  logic        grant_r;
  logic        grant_nxt;
  logic        deny_r;
  logic        deny_nxt;
  logic        initRise;
  logic        readBlk;
  logic        wpAll;
  fsvp_sect_t  locks;
  logic        sectLocked;
  fsvp_guard_if gif ();

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // pin synchronisers; third init stage only feeds the edge detector
  always_ff @(posedge sys_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      initSync_r <= 3'h0;
      modeMeta_r <= 6'h00;
      modeSync_r <= 6'h00;
    end
    else if (clkEn)
    begin
      initSync_r <= {initSync_r[1:0], external_init_reset_n};
      modeMeta_r <= {3'h0, mode_select_pins};
      modeSync_r <= modeMeta_r;
    end
  end
  // init reset rise restarts the fetch, same as power-on
  assign initRise = initSync_r[1] && !initSync_r[2];
  assign parallelMode = (modeSync_r[2:0] == `FSVP_MODE_PARALLEL);

  // fetch sequencer: word one, then word two, then open the gate
  always_comb
  begin
    state_nxt = state_r;
    wOne_nxt  = wOne_r;
    wTwo_nxt  = wTwo_r;
    case (state_r)
      FSVP_IDLE:
      begin
        if (initSync_r[1])
          state_nxt = FSVP_REQ1;
      end
      FSVP_REQ1:
      begin
        if (fetchAck)
        begin
          wOne_nxt  = fetchData;
          state_nxt = FSVP_REQ2;
        end
      end
      FSVP_REQ2:
      begin
        if (fetchAck)
        begin
          wTwo_nxt  = fetchData;
          state_nxt = FSVP_DONE;
        end
      end
      FSVP_DONE:
        state_nxt = FSVP_DONE;
      default:
        state_nxt = FSVP_IDLE;
    endcase
    // a held or rising init reset discards vectors and refetches
    if (!initSync_r[1] || initRise)
    begin
      state_nxt = FSVP_IDLE;
      wOne_nxt  = 32'h0000_0000;
      wTwo_nxt  = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      state_r <= FSVP_IDLE;
      wOne_r  <= 32'h0000_0000;
      wTwo_r  <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      state_r <= state_nxt;
      wOne_r  <= wOne_nxt;
      wTwo_r  <= wTwo_nxt;
    end
  end

  // requests held level until acknowledged
  assign fetchReq  = (state_r == FSVP_REQ1) || (state_r == FSVP_REQ2);
  assign fetchAddr = (state_r == FSVP_REQ2) ? `FSVP_ADDR_GUARD_TWO
                                            : `FSVP_ADDR_GUARD_ONE;
  assign vectorsReady = (state_r == FSVP_DONE);
  assign flash_guard_word_one = wOne_r;
  assign flash_guard_word_two = wTwo_r;

  assign gif.guardOne = wOne_r;
  assign gif.guardTwo = wTwo_r;
  assign gif.valid    = vectorsReady;

  fsvp_decode u_decode (
    .g              (gif),
    .modeSelectPins (modeSync_r[2:0]),
    .sectorPresent  (sectorPresent),
    .readBlock      (readBlk),
    .writeProtAll   (wpAll),
    .sectorLocked   (locks)
  );
  assign readBlocked    = readBlk;
  assign writeProtected = wpAll;
  assign sectorLocked   = locks;
  // out-of-range sector index reads as unlocked
  assign sectLocked = (accSector < 5'd24) ? locks[accSector] : 1'b0;

  // access arbitration; registered one cycle after the request
  always_comb
  begin
    grant_nxt = 1'b0;
    deny_nxt  = 1'b0;
    if (accRead || accWrite)
    begin
      if (!vectorsReady)
        deny_nxt = 1'b1;
      else if (accRead && readBlk)
        deny_nxt = 1'b1;
      else if (accWrite && sectLocked)
        deny_nxt = 1'b1;
      else
        grant_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      grant_r <= 1'b0;
      deny_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      grant_r <= grant_nxt;
      deny_r  <= deny_nxt;
    end
  end
  assign accGrant  = grant_r;
  assign accDenied = deny_r;

  property p_no_grant_before_fetch;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (clkEn && !vectorsReady && (accRead || accWrite)) |=> (!accGrant && accDenied);
  endproperty
  a_no_grant_before_fetch: assert property (p_no_grant_before_fetch)
    else $error("access granted before vectors fetched");

  property p_order;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (state_r == FSVP_REQ1 && fetchAck && clkEn && initSync_r[1] && !initRise)
        |=> (fetchAddr == `FSVP_ADDR_GUARD_TWO && wOne_r == $past(fetchData));
  endproperty
  a_order: assert property (p_order)
    else $error("second guard word not requested after first");

  property p_read_block;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (vectorsReady && wOne_r[31:16] == 16'h0001 && modeSync_r[2:0] != 3'h0)
        |-> readBlocked;
  endproperty
  a_read_block: assert property (p_read_block)
    else $error("read protection not applied");

  property p_wp_all;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (vectorsReady && wOne_r[31:17] == 15'h0001) |-> writeProtected;
  endproperty
  a_wp_all: assert property (p_wp_all)
    else $error("write protection missing in some mode");

  property p_wp_level;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (vectorsReady && wOne_r[31:17] == 15'h0003) |-> (writeProtected == (modeSync_r[2:0] != 3'h0));
  endproperty
  a_wp_level: assert property (p_wp_level)
    else $error("write protection level misapplied");

  property p_small_lock;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (writeProtected && !wOne_r[4] && sectorPresent[4]) |-> sectorLocked[4];
  endproperty
  a_small_lock: assert property (p_small_lock)
    else $error("small sector four not locked");

  property p_big_lock;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (!writeProtected) |-> (sectorLocked == 24'h00_0000);
  endproperty
  a_big_lock: assert property (p_big_lock)
    else $error("sector lock without write protection");

  property p_absent;
    @(posedge sys_clk) disable iff (!rstSync_r)
      (vectorsReady && wOne_r[31:19] != 13'h0000) |-> (!readBlocked && !writeProtected);
  endproperty
  a_absent: assert property (p_absent)
    else $error("undocumented code still protects");
endmodule

// >>> test/fsvp_flash_model.sv
// flash array stand-in: serves the two guard words after an adjustable lag
// assumes fetchReq is held until it is acknowledged
`timescale 1ns/100ps
`include "fsvp_defines.svh"
module fsvp_flash_model
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        fetchReq,
  input  wire logic [23:0] fetchAddr,
  input  wire logic [31:0] wordOne,
  input  wire logic [31:0] wordTwo,
  input  wire logic [1:0]  lag,
  output logic             fetchAck,
  output logic [31:0]      fetchData
);
  logic [1:0] waitCnt;

  // one-cycle ack per word; data toggles outside the ack so stale values never match
  always @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      fetchAck  <= 1'b0;
      fetchData <= 32'h0000_0000;
      waitCnt   <= 2'h0;
    end
    else if (fetchReq && !fetchAck && waitCnt >= lag)
    begin
      fetchAck  <= 1'b1;
      waitCnt   <= 2'h0;
      // only the two guard locations return guard words
      fetchData <= (fetchAddr == `FSVP_ADDR_GUARD_ONE) ? wordOne :
                   (fetchAddr == `FSVP_ADDR_GUARD_TWO) ? wordTwo : ~fetchData;
    end
    else
    begin
      fetchAck  <= 1'b0;
      fetchData <= ~fetchData;
      waitCnt   <= fetchReq ? waitCnt + 2'h1 : 2'h0;
    end
endmodule

// >>> test/tb_top.sv
// bench for the flash guard logic: refetch, decode per mode, access answers
// assumes the flash stand-in model and the design files are compiled first
`timescale 1ns/100ps
`include "fsvp_defines.svh"
module tb_top import fsvp_pkg::*;;
  logic        sys_clk, nrst, initResetN, accRead, accWrite, en;
  logic [2:0]  mode;
  logic [4:0]  accSector, sec;
  logic [1:0]  lag;
  logic [31:0] w1, w2, lfsr, gOne, gTwo, fetchData;
  logic [23:0] fetchAddr;
  fsvp_sect_t  present, locked, lk;
  logic        fetchReq, fetchAck, accGrant, accDenied, vectorsReady;
  logic        readBlocked, writeProtected, parallelMode, rb, wp;
  int          failures, checks_done, n;

  fsvp_top dut (.sys_clk(sys_clk), .nrst(nrst), .clkEn(en),
    .external_init_reset_n(initResetN), .mode_select_pins(mode), .sectorPresent(present),
    .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck), .fetchData(fetchData),
    .accRead(accRead), .accWrite(accWrite), .accSector(accSector), .accGrant(accGrant),
    .accDenied(accDenied), .vectorsReady(vectorsReady), .readBlocked(readBlocked),
    .writeProtected(writeProtected), .sectorLocked(locked), .parallelMode(parallelMode),
    .flash_guard_word_one(gOne), .flash_guard_word_two(gTwo));
  fsvp_flash_model flash (.sys_clk(sys_clk), .nrst(nrst), .fetchReq(fetchReq),
    .fetchAddr(fetchAddr), .wordOne(w1), .wordTwo(w2), .lag(lag), .fetchAck(fetchAck),
    .fetchData(fetchData));

  // free-running 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // random source with a fixed start value, so runs repeat
  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    return lfsr;
  endfunction
  // only the six listed control codes count; anything else leaves flash open
  function automatic logic docCode(logic [31:0] w);
    return (w[31:19] == 13'h0000) && (w[18:16] inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7});
  endfunction
  function automatic fsvp_sect_t expLock(logic [31:0] a, logic [31:0] b, logic p, fsvp_sect_t s);
    return p ? (~{b[15:0], a[7:0]} & s) : 24'h00_0000;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // request held one cycle, answer looked at one cycle later; caller releases
  task automatic acc(input logic rd, input logic [4:0] sec, input logic grant);
    accRead = rd;
    accWrite = !rd;
    accSector = sec;
    @(negedge sys_clk);
    chk(32'({accGrant, accDenied}), 32'({grant, !grant}));
  endtask
  // init reset pulse under a frozen enable first: nothing may move until enable returns;
  // then early access, then bounded wait for both words
  task automatic refetch();
    en = 1'b0;
    initResetN = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(32'(vectorsReady), 32'h0000_0001);
    en = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(32'(vectorsReady), 32'h0000_0000);
    initResetN = 1'b1;
    @(negedge sys_clk);
    acc(1'b1, 5'h04, 1'b0);
    accRead = 1'b0;
    for (n = 0; n < 60 && vectorsReady !== 1'b1; n++)
      @(negedge sys_clk);
    if (vectorsReady !== 1'b1)
    begin
      failures++;
      results();
    end
    chk(gOne, w1);
    chk(gTwo, w2);
  endtask

  // main sequence: 8 documented-range codes, then random and undocumented words
  initial
  begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    initResetN = 1'b1;
    en = 1'b1;
    mode = 3'h7;
    present = 24'hff_ffff;
    {accRead, accWrite, accSector, lag, w1, w2} = '0;
    failures = 0;
    checks_done = 0;
    lfsr = 32'h908b_2b95;
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    // power-on fetch with an undocumented code: flash stays open once the wait is kept
    w1 = 32'hffff_ffef;
    w2 = nxt();
    repeat (`FSVP_POWER_ON_WAIT) @(negedge sys_clk);
    chk(32'(vectorsReady), 32'h0000_0001);
    chk(gOne, w1);
    chk(gTwo, w2);
    acc(1'b1, 5'h00, 1'b1);
    acc(1'b0, 5'h04, 1'b1);
    accWrite = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      w1 = nxt();
      if (i < 8)
        w1[31:16] = {13'h0000, 3'(i)};
      else if (i[0])
        w1[31:19] = 13'h0000;
      w1[4] = 1'b0;
      w2 = nxt();
      present = i[1] ? 24'(nxt()) : 24'hff_ffff;
      lag = 2'(nxt());
      refetch();
      // one full programmer wait after an init rise; the rest use the short path
      if (i == 0)
        repeat (`FSVP_INIT_WAIT) @(negedge sys_clk);
      for (int m = 0; m < 8; m++)
      begin
        mode = 3'(m);
        repeat (4) @(negedge sys_clk);
        rb = docCode(w1) && w1[16] && mode != 3'h0;
        wp = docCode(w1) && w1[17] && (!w1[18] || mode != 3'h0);
        lk = expLock(w1, w2, wp, present);
        chk(32'(parallelMode), 32'(mode == 3'h7));
        chk(32'(readBlocked), 32'(rb));
        chk(32'(writeProtected), 32'(wp));
        chk(32'(locked), 32'(lk));
        sec = 5'(nxt());
        acc(1'b1, sec, !rb);
        acc(1'b0, sec, (sec < 5'd24) ? !lk[sec] : 1'b1);
        acc(1'b0, 5'h04, !lk[4]);
        accWrite = 1'b0;
      end
      $display("test %0d done", i);
    end
    results();
  end
endmodule
